// File: rtl/rhp_pkg.sv
package rhp_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] RHP_OFS_DESC_B = 8'h4C;
  localparam logic [7:0] RHP_OFS_STATUS = 8'h50;

  // ---------------------------------------------------------------
  // port descriptor field layout
  // ---------------------------------------------------------------
  localparam int RHP_MASK_LSB = 16;
  localparam int RHP_REMOV_LSB = 0;
  localparam int RHP_MAX_PORTS = 15;

  // ---------------------------------------------------------------
  // hub status bit positions
  // ---------------------------------------------------------------
  localparam int RHP_BIT_WAKE_CLR = 31;
  localparam int RHP_BIT_OC_CHG = 17;
  localparam int RHP_BIT_PWR_ON = 16;
  localparam int RHP_BIT_WAKE_EN = 15;
  localparam int RHP_BIT_OC_IND = 1;
  localparam int RHP_BIT_PWR_OFF = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RHP_STATUS_RST = 32'h0000_0000;
  localparam logic [15:0] RHP_MASK_RST = 16'h0000;

  // register bus request
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rhp_req_t;

endpackage

// File: rtl/rhp_port_power.sv
// per-port power switch state
module rhp_port_power #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic per_port_mode,
  input wire logic [NUM_PORTS:1] port_power_mask,
  input wire logic global_on,
  input wire logic global_off,
  input wire logic [NUM_PORTS:1] port_set,
  input wire logic [NUM_PORTS:1] port_clr,
  output logic [NUM_PORTS:1] port_power
);

  logic [NUM_PORTS:1] pwr_ff;
  logic [NUM_PORTS:1] nxt_pwr;
  logic [NUM_PORTS:1] global_sel;

  // in global mode the mask field has no meaning
  assign global_sel = per_port_mode ? ~port_power_mask : '1;
  assign port_power = pwr_ff;

  // in per-port mode masked ports follow per-port commands, others the global ones
  always_comb
  begin
    for (int i = 1; i <= NUM_PORTS; i++)
    begin
      nxt_pwr[i] = pwr_ff[i];
      if (global_sel[i])
      begin
        if (global_on)
          nxt_pwr[i] = 1'b1;
        else if (global_off)
          nxt_pwr[i] = 1'b0;
      end
      else
      begin
        if (port_set[i])
          nxt_pwr[i] = 1'b1;
        else if (port_clr[i])
          nxt_pwr[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pwr_ff <= '0;
    else if (clk_en)
      pwr_ff <= nxt_pwr;
  end

endmodule

// File: rtl/rhp_regs.sv
// Behaviour
// - masked ports in per-port mode change power only by per-port commands
// - ports with clear mask bit follow global power on and off commands
// - in global switching mode the mask field is ignored
// - mask bit 0 reserved, bit n belongs to port n
// - low sixteen descriptor bits flag non-removable devices per port
// - removable flag bit 0 reserved, bit n belongs to port n
// - hub status low half, matching change flags in upper half
// - status bit positions fixed, all reset zero, indicator read-only
// - writing one to power-on bit powers selected ports; reads zero
// - writing one to power-off bit unpowers selected ports unless power-on is written with it; reads zero
// - overcurrent change flag set on indicator change, cleared by writing one
// - bit 15 write one sets wake enable, bit 31 write one clears it
module rhp_regs #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire rhp_pkg::rhp_req_t req,
  input wire logic per_port_mode,
  input wire logic overcurrent_in,
  input wire logic [NUM_PORTS:1] port_set,
  input wire logic [NUM_PORTS:1] port_clr,
  output logic [31:0] rdata,
  output logic [NUM_PORTS:1] port_power,
  output logic wake_on_connect_enable
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [NUM_PORTS:1] port_power_mask_ff;
  logic [NUM_PORTS:1] nonremovable_flags_ff;
  logic wake_on_connect_enable_ff;
  logic overcurrent_change_flag_ff;
  logic overcurrent_indicator_ff;
  logic oc_meta_ff;
  logic oc_sync_ff;
  logic strap_done_ff;
  logic [31:0] rdata_ff;
  logic [NUM_PORTS:1] pwr_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // one compare serves all four strobes; an unmapped offset hits nothing
  function automatic logic bus_hit(
    input rhp_pkg::rhp_req_t r,
    input logic want_wr,
    input logic [7:0] ofs
  );
    return r.sel & (r.wr == want_wr) & (r.addr == ofs);
  endfunction

  wire wr_desc = bus_hit(req, 1'b1, rhp_pkg::RHP_OFS_DESC_B);
  wire wr_stat = bus_hit(req, 1'b1, rhp_pkg::RHP_OFS_STATUS);
  wire rd_desc = bus_hit(req, 1'b0, rhp_pkg::RHP_OFS_DESC_B);
  wire rd_stat = bus_hit(req, 1'b0, rhp_pkg::RHP_OFS_STATUS);
  // status command bits act only in the write cycle and are never stored
  wire global_on = wr_stat & req.wdata[rhp_pkg::RHP_BIT_PWR_ON];
  wire global_off = wr_stat & req.wdata[rhp_pkg::RHP_BIT_PWR_OFF];
  wire wake_set = wr_stat & req.wdata[rhp_pkg::RHP_BIT_WAKE_EN];
  wire wake_clr = wr_stat & req.wdata[rhp_pkg::RHP_BIT_WAKE_CLR];
  wire oc_clr = wr_stat & req.wdata[rhp_pkg::RHP_BIT_OC_CHG];
  wire oc_edge = oc_sync_ff ^ overcurrent_indicator_ff;

  // write data fields cut to the configured port count
  wire [NUM_PORTS:1] wr_mask = req.wdata[rhp_pkg::RHP_MASK_LSB + 1 +: NUM_PORTS];
  wire [NUM_PORTS:1] wr_flags = req.wdata[rhp_pkg::RHP_REMOV_LSB + 1 +: NUM_PORTS];

  // change set wins over a same-cycle clear, so no event is lost
  wire nxt_oc_chg = oc_edge | (overcurrent_change_flag_ff & ~oc_clr);
  // clear wins when both wake bits are written together
  wire nxt_wake_en = ~wake_clr & (wake_set | wake_on_connect_enable_ff);

  // ---------------------------------------------------------------
  // read images; reserved and command bits read zero
  // ---------------------------------------------------------------
  function automatic logic [15:0] port_field(input logic [NUM_PORTS:1] v);
    logic [15:0] f;
    f = '0;
    f[NUM_PORTS:1] = v;
    return f;
  endfunction

  wire [31:0] desc_img = {port_field(port_power_mask_ff),
                          port_field(nonremovable_flags_ff)};

  function automatic logic [31:0] status_image(
    input logic oc_chg,
    input logic wake_en,
    input logic oc_ind
  );
    logic [31:0] img;
    img = 32'h0000_0000;
    img[rhp_pkg::RHP_BIT_OC_CHG] = oc_chg;
    img[rhp_pkg::RHP_BIT_WAKE_EN] = wake_en;
    img[rhp_pkg::RHP_BIT_OC_IND] = oc_ind;
    // command bits act on write only and never hold state
    img[rhp_pkg::RHP_BIT_PWR_ON] = 1'b0;
    img[rhp_pkg::RHP_BIT_PWR_OFF] = 1'b0;
    img[rhp_pkg::RHP_BIT_WAKE_CLR] = 1'b0;
    return img;
  endfunction

  // every reserved status bit stays at zero on read
  wire [31:0] stat_img = status_image(overcurrent_change_flag_ff,
                                      wake_on_connect_enable_ff,
                                      overcurrent_indicator_ff);

  // zero on enabled cycles without a read; a stale word lingers only while clk_en is low
  wire [31:0] nxt_rdata = rd_desc ? desc_img : (rd_stat ? stat_img : 32'h0000_0000);

  // ---------------------------------------------------------------
  // overcurrent pin synchroniser
  // ---------------------------------------------------------------
  // only the second stage feeds logic; the first may go metastable
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      oc_meta_ff <= 1'b0;
      oc_sync_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      oc_meta_ff <= overcurrent_in;
      oc_sync_ff <= oc_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // hub status; change set wins over a same-cycle clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      overcurrent_indicator_ff <= 1'b0;
      overcurrent_change_flag_ff <= 1'b0;
      wake_on_connect_enable_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      overcurrent_indicator_ff <= oc_sync_ff;
      overcurrent_change_flag_ff <= nxt_oc_chg;
      wake_on_connect_enable_ff <= nxt_wake_en;
    end
  end

  // ---------------------------------------------------------------
  // descriptor; removable flag of port NUM_PORTS defaults by port count
  // ---------------------------------------------------------------
  // the field helpers put port n at field bit n, so NUM_PORTS must
  // stay at or below rhp_pkg::RHP_MAX_PORTS or the upper half would
  // be overrun; larger hubs need a wider register, not a parameter
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      port_power_mask_ff <= '0;
      nonremovable_flags_ff <= '0;
      strap_done_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_done_ff <= 1'b1;
      // strap cycle runs once after reset; a write there is dropped
      if (!strap_done_ff)
        nonremovable_flags_ff[NUM_PORTS] <= (NUM_PORTS >= 2);
      else if (wr_desc)
      begin
        port_power_mask_ff <= wr_mask;
        nonremovable_flags_ff <= wr_flags;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data and outputs, all registered
  // ---------------------------------------------------------------
  // wake output trails its status bit by one cycle, power trails the
  // command by two; software never sees the difference through rdata
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_ff <= 32'h0000_0000;
      port_power <= '0;
      wake_on_connect_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_ff <= nxt_rdata;
      port_power <= pwr_q;
      wake_on_connect_enable <= wake_on_connect_enable_ff;
    end
  end

  assign rdata = rdata_ff;

  // ---------------------------------------------------------------
  // power switch state
  // ---------------------------------------------------------------
  // the submodule holds the switch state; this level adds the output
  // stage so every top-level output leaves straight from a flip-flop
  rhp_port_power #(
    .NUM_PORTS(NUM_PORTS)
  ) u_power (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .per_port_mode(per_port_mode),
    .port_power_mask(port_power_mask_ff),
    .global_on(global_on),
    .global_off(global_off),
    .port_set(port_set),
    .port_clr(port_clr),
    .port_power(pwr_q)
  );

endmodule

// File: tb/rhp_regs_monitor.sv
module rhp_regs_mon #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire rhp_pkg::rhp_req_t req,
  input wire logic per_port_mode,
  input wire logic overcurrent_in,
  input wire logic [NUM_PORTS:1] port_set,
  input wire logic [NUM_PORTS:1] port_clr,
  input wire logic [31:0] rdata,
  input wire logic [NUM_PORTS:1] port_power,
  input wire logic wake_on_connect_enable
);
  // ----
  // request decode
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  wire rd = clk_en && req.sel && !req.wr;
  wire ws = clk_en && req.sel && req.wr && req.addr == rhp_pkg::RHP_OFS_STATUS;
  wire st = req.addr == rhp_pkg::RHP_OFS_STATUS;
  wire ds = req.addr == rhp_pkg::RHP_OFS_DESC_B;
  // per-port pulses would race a global command, so demand a quiet window
  wire q_on = clk_en && !per_port_mode && port_clr == '0;
  wire q_off = clk_en && !per_port_mode && port_set == '0;
  // ----
  // properties
  // ----
  property p_st_rsv; rd && st |=> (rdata & 32'hFFFD_7FFD) == 32'h0000_0000; endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("status reads a zero bit high");
  property p_ds_rsv; rd && ds |=> !rdata[0] && !rdata[16]; endproperty
  a_ds_rsv: assert property (p_ds_rsv) else $error("descriptor bit 0 high");
  property p_unmap; rd && !st && !ds |=> rdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_wk_set;
    ws && req.wdata[15] && !req.wdata[31] |-> ##[1:2] wake_on_connect_enable; endproperty
  a_wk_set: assert property (p_wk_set) else $error("wake enable not set");
  property p_wk_clr; ws && req.wdata[31] |-> ##[1:2] !wake_on_connect_enable; endproperty
  a_wk_clr: assert property (p_wk_clr) else $error("wake enable not cleared");
  property p_on; ws && req.wdata[16] ##0 q_on[*2] |=> port_power == '1; endproperty
  a_on: assert property (p_on) else $error("global on missed a port");
  property p_off;
    ws && req.wdata[0] && !req.wdata[16] ##0 q_off[*2] |=> port_power == '0; endproperty
  a_off: assert property (p_off) else $error("global off missed a port");
  property p_rst; $past(reset) |-> port_power == '0 && !wake_on_connect_enable; endproperty
  a_rst: assert property (p_rst) else $error("state not zero after reset");
  c_rd: cover property (rd && st);
  c_pp: cover property (ws && req.wdata[16] && per_port_mode);
  c_set: cover property (per_port_mode && port_set != '0);
endmodule

bind rhp_regs rhp_regs_mon #(.NUM_PORTS(NUM_PORTS)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .req(req),
  .per_port_mode(per_port_mode), .overcurrent_in(overcurrent_in),
  .port_set(port_set), .port_clr(port_clr), .rdata(rdata),
  .port_power(port_power), .wake_on_connect_enable(wake_on_connect_enable)
);

// File: tb/rhp_regs_test.sv
module rhp_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DSC = rhp_pkg::RHP_OFS_DESC_B;
  localparam logic [7:0] STS = rhp_pkg::RHP_OFS_STATUS;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic per_port_mode = 1'b0;
  logic overcurrent_in = 1'b0;
  logic [2:1] port_set = 2'h0;
  logic [2:1] port_clr = 2'h0;
  logic [2:1] port_power;
  logic [31:0] rdata;
  logic wake_on_connect_enable;
  rhp_pkg::rhp_req_t req = '0;
  int err_total = 0;
  int n_tests = 0;
  always #10 clk_sys = ~clk_sys;
  rhp_regs #(.NUM_PORTS(2)) dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .req(req),
    .per_port_mode(per_port_mode), .overcurrent_in(overcurrent_in),
    .port_set(port_set), .port_clr(port_clr), .rdata(rdata),
    .port_power(port_power), .wake_on_connect_enable(wake_on_connect_enable)
  );
  // ----
  // shared tasks
  // ----
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // #1 lets the edge's updates land before sampling
  task automatic wt(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b1, a, d};
    @(posedge clk_sys);
    req.sel <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, 32'h0000_0000};
    @(posedge clk_sys);
    req.sel <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  task automatic pwr(logic [2:1] exp);
    wt(2);
    chk("port_power", {30'h0, exp}, {30'h0, port_power});
  endtask
  task automatic pulse(logic [2:1] s, logic [2:1] c);
    @(posedge clk_sys);
    port_set <= s;
    port_clr <= c;
    @(posedge clk_sys);
    port_set <= 2'h0;
    port_clr <= 2'h0;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rreg(DSC, 32'h0000_0004);
    rreg(STS, 32'h0000_0000);
    rreg(8'h60, 32'h0000_0000);
    wreg(DSC, 32'hFFFF_FFFF);
    rreg(DSC, 32'h0006_0006);
    wreg(DSC, 32'h0002_0002);
    rreg(DSC, 32'h0002_0002);
    $display("t_regs done");
  endtask
  // port 1 is masked but global mode must ignore that
  task automatic t_global();
    wreg(STS, 32'h0001_0000);
    pwr(2'h3);
    wreg(STS, 32'h0000_0001);
    pwr(2'h0);
    wreg(STS, 32'h0001_0001);
    pwr(2'h3);
    rreg(STS, 32'h0000_0000);
    $display("t_global done");
  endtask
  task automatic t_port();
    @(posedge clk_sys);
    per_port_mode <= 1'b1;
    wreg(STS, 32'h0000_0001);
    pwr(2'h1);
    pulse(2'h0, 2'h1);
    pwr(2'h0);
    wreg(STS, 32'h0001_0000);
    pwr(2'h2);
    pulse(2'h1, 2'h0);
    pwr(2'h3);
    wreg(STS, 32'h0000_0001);
    pwr(2'h1);
    $display("t_port done");
  endtask
  task automatic t_wake();
    wreg(STS, 32'h0000_8000);
    wreg(STS, 32'h0000_0000);
    rreg(STS, 32'h0000_8000);
    chk("wake", 32'h0000_0001, {31'h0, wake_on_connect_enable});
    wreg(STS, 32'h8000_8000);
    rreg(STS, 32'h0000_0000);
    $display("t_wake done");
  endtask
  // indicator passes a two-flop synchroniser, so allow four edges
  task automatic t_oc();
    @(posedge clk_sys);
    overcurrent_in <= 1'b1;
    wt(4);
    rreg(STS, 32'h0002_0002);
    wreg(STS, 32'h0002_0000);
    rreg(STS, 32'h0000_0002);
    @(posedge clk_sys);
    overcurrent_in <= 1'b0;
    wt(4);
    rreg(STS, 32'h0002_0000);
    $display("t_oc done");
  endtask
  // with the clock enable low a write must leave every register alone
  task automatic t_freeze();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wreg(STS, 32'h0001_8000);
    wt(2);
    chk("frozen power", 32'h0000_0001, {30'h0, port_power});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rreg(STS, 32'h0002_0000);
    $display("t_freeze done");
  endtask
  // a mid-run reset clears power and wake and restores the defaults
  task automatic t_reset();
    wreg(STS, 32'h0001_8000);
    wt(2);
    chk("power before reset", 32'h0000_0003, {30'h0, port_power});
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk("power in reset", 32'h0000_0000, {30'h0, port_power});
    chk("wake in reset", 32'h0000_0000, {31'h0, wake_on_connect_enable});
    rreg(DSC, 32'h0000_0004);
    rreg(STS, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_global();
    t_port();
    t_wake();
    t_oc();
    t_freeze();
    t_reset();
    complete_run();
  end
  // a hang counts as a mismatch
  initial
  begin
    #100us;
    err_total++;
    complete_run();
  end
endmodule
